// ### gpr_pad_model.sv
`timescale 1ns/100ps
`default_nettype none

// Pads seen from the port: outside drivers, pull-ups and floating nodes.
module gpr_pad_model
(
    // Clock for the floating pattern.
    input wire logic clk,
    // Port side.
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_en,
    // Outside drivers.
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] level
);
    logic [7:0] float_q = 8'h55;

    // A pad nobody drives or pulls has no level, so it toggles and never reads stable.
    always @(posedge clk)
    begin
        float_q <= ~float_q;
    end

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe[i])
                level[i] = pin_out[i];
            else if (ext_en[i])
                level[i] = ext_val[i];
            else if (pullup_en[i])
                level[i] = 1'b1;
            else
                level[i] = float_q[i];
        end
    end
endmodule

`default_nettype wire

// ### gpr_pkg.sv
package gpr_pkg;

    // Register bus geometry.
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;

    // Register indices on the plain register port.
    localparam logic [2:0] REG_DIR = 3'h0;
    localparam logic [2:0] REG_LATCH = 3'h1;
    localparam logic [2:0] REG_PIN_STATE = 3'h2;
    localparam logic [2:0] REG_PIN_FUNC = 3'h3;
    localparam logic [2:0] REG_OTYPE_LO = 3'h4;
    localparam logic [2:0] REG_OTYPE_HI = 3'h5;
    localparam logic [2:0] REG_PULLUP = 3'h6;

    // Port flavours: the G port has the mode-pin bit, the E port has the wide pin 1 field.
    localparam logic [1:0] KIND_PLAIN = 2'h0;
    localparam logic [1:0] KIND_G = 2'h1;
    localparam logic [1:0] KIND_E = 2'h2;

    // Reset values.
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] PIN_FUNC_RST = 8'h00;
    localparam logic [7:0] PIN_FUNC_RST_G = 8'h80;
    localparam logic [7:0] OTYPE_RST = 8'h00;
    localparam logic [7:0] PULLUP_RST = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // Writable bits of the output-type registers; all others read as zero.
    localparam logic [7:0] OTYPE_LO_WMASK = 8'h55;
    localparam logic [7:0] OTYPE_LO_WMASK_E = 8'h5d;
    localparam logic [7:0] OTYPE_HI_WMASK = 8'h55;

    // Output-type field layout.
    localparam int OT_FIELD_W = 2;
    localparam int OT_PIN0_LSB = 0;
    localparam int OT_PIN1_LSB = 2;
    localparam int OT_HI_FIRST_PIN = 4;
    localparam int MODE_PIN_BIT = 7;
    localparam int WIDE_PIN = 1;

    // Output-type codes.
    localparam logic [1:0] OT_CMOS = 2'h0;
    localparam logic [1:0] OT_NCH_OD = 2'h1;
    localparam logic [1:0] OT_PCH_OD = 2'h2;
    localparam logic [1:0] OT_BAD = 2'h3;

endpackage

// ### gpr_port.sv
`timescale 1ns/100ps
`default_nettype none

module gpr_port #(
    parameter logic [1:0] PORT_KIND = gpr_pkg::KIND_PLAIN
)
(
    // Clock and reset.
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // Register port.
    input wire logic [2:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Pads.
    input wire logic [7:0] PIN_IN,
    output logic [7:0] PIN_OUT,
    output logic [7:0] PIN_OE,
    output logic [7:0] PULLUP_EN,
    // Multiplexed peripheral functions.
    input wire logic [7:0] PERIPH_OUT,
    input wire logic [7:0] PERIPH_OE,
    output logic [7:0] PERIPH_IN,
    output logic [7:0] PERIPH_SEL
);

    logic [7:0] dir_q;
    logic [7:0] latch_q;
    logic [7:0] func_q;
    logic [7:0] otype_lo_q;
    logic [7:0] otype_lo_d;
    logic [7:0] otype_hi_q;
    logic [7:0] pullup_q;
    logic [7:0] pin_state;
    logic [7:0] rd_d;
    logic [7:0] rdata_q;
    logic [7:0] pin_out_q;
    logic [7:0] pin_oe_q;
    logic [7:0] pin_out_d;
    logic [7:0] pin_oe_d;
    logic [7:0] pullup_out_q;

    localparam logic [7:0] FUNC_RST =
        (PORT_KIND == gpr_pkg::KIND_G) ? gpr_pkg::PIN_FUNC_RST_G : gpr_pkg::PIN_FUNC_RST;
    localparam logic [7:0] LO_WMASK =
        (PORT_KIND == gpr_pkg::KIND_E) ? gpr_pkg::OTYPE_LO_WMASK_E : gpr_pkg::OTYPE_LO_WMASK;

    function automatic logic wr_hit(input logic wr, input logic [2:0] a, input logic [2:0] r);
        return wr && (a == r);
    endfunction

    // Output type of one pin from the two type registers.
    function automatic logic [1:0] pin_type(
        input int idx,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [1:0] t;
        t = gpr_pkg::OT_CMOS;
        if (idx == 0)
        begin
            t = {1'b0, lo[gpr_pkg::OT_PIN0_LSB]};
        end
        else if (idx == gpr_pkg::WIDE_PIN)
        begin
            t = lo[gpr_pkg::OT_PIN1_LSB +: gpr_pkg::OT_FIELD_W];
        end
        else if (idx >= gpr_pkg::OT_HI_FIRST_PIN)
        begin
            t = {1'b0, hi[gpr_pkg::OT_FIELD_W * (idx - gpr_pkg::OT_HI_FIRST_PIN)]};
        end
        return t;
    endfunction

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            dir_q <= gpr_pkg::DIR_RST;
        end
        else if (wr_hit(REG_WR, REG_ADDR, gpr_pkg::REG_DIR))
        begin
            dir_q <= REG_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            latch_q <= gpr_pkg::LATCH_RST;
        end
        else if (wr_hit(REG_WR, REG_ADDR, gpr_pkg::REG_LATCH))
        begin
            latch_q <= REG_WDATA;
        end
    end

    // Port G resets with its top pin handed to the mode-pin function.
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            func_q <= FUNC_RST;
        end
        else if (wr_hit(REG_WR, REG_ADDR, gpr_pkg::REG_PIN_FUNC))
        begin
            func_q <= REG_WDATA;
        end
    end

    // Upper field bits are not stored, so they read as zero, except pin 1's on the E port. On the E port
    // a write of the forbidden code to pin 1 leaves that field as it was.
    always_comb
    begin
        otype_lo_d = REG_WDATA & LO_WMASK;
        if (PORT_KIND == gpr_pkg::KIND_E &&
            REG_WDATA[gpr_pkg::OT_PIN1_LSB +: gpr_pkg::OT_FIELD_W] == gpr_pkg::OT_BAD)
        begin
            otype_lo_d[gpr_pkg::OT_PIN1_LSB +: gpr_pkg::OT_FIELD_W] =
                otype_lo_q[gpr_pkg::OT_PIN1_LSB +: gpr_pkg::OT_FIELD_W];
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            otype_lo_q <= gpr_pkg::OTYPE_RST;
        end
        else if (wr_hit(REG_WR, REG_ADDR, gpr_pkg::REG_OTYPE_LO))
        begin
            otype_lo_q <= otype_lo_d;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            otype_hi_q <= gpr_pkg::OTYPE_RST;
        end
        else if (wr_hit(REG_WR, REG_ADDR, gpr_pkg::REG_OTYPE_HI))
        begin
            otype_hi_q <= REG_WDATA & gpr_pkg::OTYPE_HI_WMASK;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            pullup_q <= gpr_pkg::PULLUP_RST;
        end
        else if (wr_hit(REG_WR, REG_ADDR, gpr_pkg::REG_PULLUP))
        begin
            pullup_q <= REG_WDATA;
        end
    end

    gpr_sync2 #(
        .W(gpr_pkg::DATA_W)
    ) u_pin_sync (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .d(PIN_IN),
        .q(pin_state)
    );

    always_comb
    begin
        case (REG_ADDR)
            gpr_pkg::REG_DIR: rd_d = dir_q;
            gpr_pkg::REG_LATCH: rd_d = latch_q;
            gpr_pkg::REG_PIN_STATE: rd_d = pin_state;
            gpr_pkg::REG_PIN_FUNC: rd_d = func_q;
            gpr_pkg::REG_OTYPE_LO: rd_d = otype_lo_q;
            gpr_pkg::REG_OTYPE_HI: rd_d = otype_hi_q;
            gpr_pkg::REG_PULLUP: rd_d = pullup_q;
            default: rd_d = gpr_pkg::RDATA_IDLE;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            rdata_q <= gpr_pkg::RDATA_IDLE;
        end
        else if (REG_RD)
        begin
            rdata_q <= rd_d;
        end
        else
        begin
            rdata_q <= gpr_pkg::RDATA_IDLE;
        end
    end

    // The chosen source (latch or peripheral) is then shaped by the output type.
    // Open-drain types only ever drive toward one rail.
    genvar gi;
    generate
        for (gi = 0; gi < gpr_pkg::DATA_W; gi++)
        begin : g_pin
            logic val;
            logic en;
            logic [1:0] ot;
            assign ot = pin_type(gi, otype_lo_q, otype_hi_q);
            assign val = func_q[gi] ? PERIPH_OUT[gi] : latch_q[gi];
            assign en = func_q[gi] ? PERIPH_OE[gi] : dir_q[gi];
            always_comb
            begin
                case (ot)
                    gpr_pkg::OT_NCH_OD:
                    begin
                        pin_out_d[gi] = 1'b0;
                        pin_oe_d[gi] = en && !val;
                    end
                    gpr_pkg::OT_PCH_OD:
                    begin
                        pin_out_d[gi] = 1'b1;
                        pin_oe_d[gi] = en && val;
                    end
                    default:
                    begin
                        pin_out_d[gi] = val;
                        pin_oe_d[gi] = en;
                    end
                endcase
            end
        end
    endgenerate

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            pin_out_q <= gpr_pkg::LATCH_RST;
            pin_oe_q <= gpr_pkg::DIR_RST;
        end
        else
        begin
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    // A pull-up fights an active driver, so it is released while the pin drives.
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            pullup_out_q <= gpr_pkg::PULLUP_RST;
        end
        else
        begin
            pullup_out_q <= pullup_q & ~pin_oe_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign PIN_OUT = pin_out_q;
    assign PIN_OE = pin_oe_q;
    assign PULLUP_EN = pullup_out_q;
    assign PERIPH_IN = pin_state;
    assign PERIPH_SEL = func_q;

    AST_DIR_WRITE: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        REG_WR && REG_ADDR == gpr_pkg::REG_DIR ##1 REG_RD && REG_ADDR == gpr_pkg::REG_DIR
        |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("direction readback differs from written value");

    AST_LATCH_DRIVE: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        !func_q[3] && dir_q[3] |=> PIN_OE[3] && PIN_OUT[3] == $past(latch_q[3]))
        else $error("general output pin does not show latch level");

    AST_PIN_READ: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        REG_RD && REG_ADDR == gpr_pkg::REG_PIN_STATE |=> REG_RDATA == $past(PIN_IN, 3))
        else $error("pin state read does not match pin level");

    AST_FUNC_RESET: assert property (
        @(posedge CORE_CLK)
        $past(SYS_RST) && !SYS_RST |-> func_q == FUNC_RST)
        else $error("pin function register has wrong reset value");

    AST_MODE_PIN_RESET: assert property (
        @(posedge CORE_CLK)
        $past(SYS_RST) && !SYS_RST && PORT_KIND == gpr_pkg::KIND_G
        |-> func_q[gpr_pkg::MODE_PIN_BIT])
        else $error("mode pin not selected after reset");

    AST_PIN1_FIELD: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        otype_lo_q[gpr_pkg::OT_PIN1_LSB] && !otype_lo_q[gpr_pkg::OT_PIN1_LSB + 1]
        |=> !(PIN_OE[1] && PIN_OUT[1]))
        else $error("pin 1 open-drain field not honoured");

    AST_NCH_NO_HIGH: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        otype_lo_q[gpr_pkg::OT_PIN0_LSB] |=> !(PIN_OE[0] && PIN_OUT[0]))
        else $error("open-drain pin 0 drove high");

    AST_UPPER_ZERO: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        REG_RD && REG_ADDR == gpr_pkg::REG_OTYPE_HI
        |=> (REG_RDATA & ~gpr_pkg::OTYPE_HI_WMASK) == 8'h00)
        else $error("upper type bits read nonzero");

    AST_NO_BAD_CODE: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        otype_lo_q[gpr_pkg::OT_PIN1_LSB +: gpr_pkg::OT_FIELD_W] != gpr_pkg::OT_BAD)
        else $error("forbidden output type stored for pin 1");

    AST_HI_FIELD: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        otype_hi_q[6] |=> !(PIN_OE[7] && PIN_OUT[7]))
        else $error("pin 7 open-drain field not honoured");

    AST_PULLUP_GATE: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (PULLUP_EN & ~$past(pullup_q)) == 8'h00 && (PULLUP_EN & PIN_OE) == 8'h00)
        else $error("pull-up enabled without control bit or while driving");

    AST_NO_STRAY_DRIVE: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        !dir_q[2] && !func_q[2] |=> !PIN_OE[2])
        else $error("input pin driven");

    AST_SYNC_DEPTH: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        $past(!SYS_RST, 2) |-> pin_state == $past(PIN_IN, 2))
        else $error("pin state not two cycles behind pad");

endmodule

`default_nettype wire

// ### gpr_port_bench.sv
`timescale 1ns/100ps
`default_nettype none

module gpr_port_bench;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] periph_out = 8'h00;
    logic [7:0] periph_oe = 8'h00;
    logic [7:0] ext_en = 8'hff;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] rdata, rdata_g, pin_in, pin_out, pin_oe, pullup_en, periph_in, periph_sel;
    logic [7:0] rv, rg;
    logic [2:0] ta [7] = '{3'h0, 3'h1, 3'h3, 3'h6, 3'h5, 3'h4, 3'h4};
    logic [7:0] td [7] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'hff, 8'hff, 8'h08};
    logic [7:0] te [7] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h55, 8'h51, 8'h08};
    logic [7:0] tg [7] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h55, 8'h55, 8'h00};
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;

    always #5 core_clk = ~core_clk;

    gpr_port #(.PORT_KIND(gpr_pkg::KIND_E)) dut_u (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .PULLUP_EN(pullup_en), .PERIPH_OUT(periph_out), .PERIPH_OE(periph_oe),
        .PERIPH_IN(periph_in), .PERIPH_SEL(periph_sel));

    // Second port of the mode-pin flavour shares the bus and is judged by read data only.
    gpr_port #(.PORT_KIND(gpr_pkg::KIND_G)) g_u (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(rdata_g), .PIN_IN(pin_in), .PIN_OUT(), .PIN_OE(), .PULLUP_EN(),
        .PERIPH_OUT(periph_out), .PERIPH_OE(periph_oe), .PERIPH_IN(), .PERIPH_SEL());

    gpr_pad_model pads_u (.clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .level(pin_in));

    task automatic end_of_test;
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rv = rdata;
        rg = rdata_g;
    endtask

    // Write then read back with no idle cycle between the strobes.
    task automatic wr_rd(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rv = rdata;
        rg = rdata_g;
    endtask

    // Register to pad takes one edge; two more leave margin.
    task automatic settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            rd(i[2:0]);
            check("reset e", rv, 8'h00);
            check("reset g", rg, (i == 3) ? 8'h80 : 8'h00);
        end
        for (int i = 0; i < 7; i++)
        begin
            wr_rd(ta[i], td[i]);
            check("rw e", rv, te[i]);
            check("rw g", rg, tg[i]);
        end
        wr(gpr_pkg::REG_PIN_STATE, 8'hff);
        rd(gpr_pkg::REG_PIN_STATE);
        check("pin state ro", rv, 8'h00);
        wr(3'h7, 8'hff);
        rd(3'h7);
        check("unmapped", rv, 8'h00);
        wr(gpr_pkg::REG_PIN_FUNC, 8'h00);
        rd(gpr_pkg::REG_PIN_FUNC);
        check("mode pin off", rg, 8'h00);
        @(posedge core_clk);
        ext_en <= 8'h00;
        periph_out <= 8'h0c;
        periph_oe <= 8'h05;
        wr(gpr_pkg::REG_DIR, 8'hff);
        wr(gpr_pkg::REG_OTYPE_LO, 8'h00);
        wr(gpr_pkg::REG_OTYPE_HI, 8'h00);
        wr(gpr_pkg::REG_LATCH, 8'ha5);
        settle();
        check("oe general", pin_oe, 8'hff);
        check("out general", pin_out, 8'ha5);
        check("pullup off", pullup_en, 8'h00);
        wr(gpr_pkg::REG_PIN_FUNC, 8'h0f);
        settle();
        check("function sel", periph_sel, 8'h0f);
        check("oe periph", pin_oe, 8'hf5);
        check("out periph", pin_out, 8'hac);
        wr(gpr_pkg::REG_PIN_FUNC, 8'h00);
        wr(gpr_pkg::REG_DIR, 8'h0f);
        settle();
        check("oe input", pin_oe, 8'h0f);
        wr(gpr_pkg::REG_DIR, 8'hff);
        wr(gpr_pkg::REG_OTYPE_LO, 8'h09);
        wr(gpr_pkg::REG_OTYPE_HI, 8'h41);
        settle();
        check("oe drain a5", pin_oe, 8'h7c);
        check("out drain a5", pin_out, 8'h26);
        wr(gpr_pkg::REG_LATCH, 8'h5a);
        settle();
        check("oe drain 5a", pin_oe, 8'hef);
        check("out drain 5a", pin_out, 8'h4a);
        wr(gpr_pkg::REG_OTYPE_LO, 8'h0d);
        rd(gpr_pkg::REG_OTYPE_LO);
        check("code 11 refused", rv, 8'h09);
        check("upper bit zero", rg, 8'h05);
        wr(gpr_pkg::REG_OTYPE_LO, 8'h00);
        wr(gpr_pkg::REG_OTYPE_HI, 8'h00);
        wr(gpr_pkg::REG_DIR, 8'h0f);
        wr(gpr_pkg::REG_LATCH, 8'h03);
        wr(gpr_pkg::REG_PULLUP, 8'hff);
        settle();
        check("pullup inputs", pullup_en, 8'hf0);
        rd(gpr_pkg::REG_PIN_STATE);
        check("pin state pulled", rv, 8'hf3);
        @(posedge core_clk);
        ext_en <= 8'hf0;
        ext_val <= 8'ha0;
        @(posedge core_clk);
        #1;
        check("sync first flop", periph_in, 8'hf3);
        @(posedge core_clk);
        #1;
        check("sync second flop", periph_in, 8'ha3);
        rd(gpr_pkg::REG_PIN_STATE);
        check("pin state driven", rv, 8'ha3);
        end_of_test();
    end
endmodule

`default_nettype wire

// ### gpr_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module gpr_sync2 #(
    parameter int W = 8
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule

`default_nettype wire
